/* File: shared/strap_cfg_map.svh */
// Register map, field positions and timing counts of the strap configuration loader
`ifndef STRAP_CFG_MAP_SVH
`define STRAP_CFG_MAP_SVH

// ==========================================================
// Management device addresses
`define DEV_PMA            5'h01
`define DEV_AN             5'h07
`define DEV_VEND           5'h1e

// ==========================================================
// Register addresses
`define REG_ADV_MID        16'h0203
`define REG_ADV_HIGH       16'h0204
`define REG_LEADER_CFG     16'h0834
`define REG_TX_LVL_CTRL    16'h08f6
`define REG_TX_LVL_ABLE    16'h08f7
`define REG_SOFT_PD        16'h8812
`define REG_SYS_STATUS     16'h8818
`define REG_CFG_STATUS     16'h8f00

// ==========================================================
// Field positions
`define BIT_ADV_LEADER     4
`define BIT_ADV_HI_ABL     13
`define BIT_ADV_HI_REQ     12
`define BIT_FORCED_LEADER  14
`define BIT_TX_LVL_HI      12
`define BIT_TX_LVL_ABLE    12
`define BIT_SOFT_PD        0
`define BIT_SYS_READY      0
`define BIT_SOFT_PD_RDY    1
`define BIT_STAT_MAC_LO    0
`define BIT_STAT_MAC_HI    1
`define BIT_STAT_BRIDGE    2
`define BIT_STAT_LVL_HI    3
`define BIT_STAT_LATCHED   4

// ==========================================================
// Reset values and timing
`define WORD_ZERO          16'h0000
`define STRAP_SETTLE       2'd2

`endif

/* File: shared/strap_cfg_pkg.sv */
// Types shared by the strap configuration loader
package strap_cfg_pkg;

  // ==========================================================
  // MAC interface mode decoded from the two select straps
  typedef enum logic [1:0] {
    MAC_RMII  = 2'h0,
    MAC_RSVD1 = 2'h1,
    MAC_RSVD2 = 2'h2,
    MAC_MII   = 2'h3
  } mac_mode_t;

  // ==========================================================
  // Bring-up sequence states, one-hot
  typedef enum logic [2:0] {
    ST_CAPTURE   = 3'b001,
    ST_POWERDOWN = 3'b010,
    ST_RUN       = 3'b100
  } cfg_state_t;

  // ==========================================================
  // Strap pin levels as one group
  typedef struct packed {
    logic high_level_disable;
    logic mac_upper;
    logic mac_lower;
    logic media_bridge;
    logic powerdown_skip;
    logic leader_pref;
  } strap_bits_t;

  // ==========================================================
  // One management access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

endpackage : strap_cfg_pkg

/* File: hw/strap_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // Pin levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

endmodule : strap_sync

/* File: hw/strap_config_tx_level.sv */
// Strap capture, transmit-level configuration registers and bring-up sequencing
`timescale 1ns/1ps
`include "strap_cfg_map.svh"

// Summary of operation
// R1: Disable strap low at reset exit sets high-level capability bit to one.
// R2: Disable strap high at reset exit clears capability bit, no 2.4 V mode.
// R3: Advertised ability, request and forced select bits load capability value at reset.
// R4: Writes of one to those three bits are dropped while capability is zero.
// R5: Forced select bit picks transmit level only when negotiation is disabled.
// R6: High level only if both ends able and at least one requests.
// R7: Local ability zero forces the 1.0 V level whatever the partner says.
// R8: Select straps 00 give RMII, 11 give MII, 01 and 10 reserved.
// R9: Pull-down defaults on both select straps give RMII mode.
// R10: Bridge strap 0 is normal operation, 1 is media-converter operation.
// R11: Media-converter operation allowed only with RMII mode selected.
// R12: In converter mode the RMII port bridges straight to the line side.
// R13: Skip strap set: no soft powerdown, negotiation starts at once, then link.
// R14: Skip strap clear: wait in powerdown until host clears the bit.
// R15: Leader strap chooses advertising prefer slave or prefer master.
// R16: Host should set request bit to prefer 2.4 V, clear it for 1.0 V.
// R17: Each strap is sensed and latched on leaving reset, used as defaults.
// R18: Skip strap sets soft powerdown default: 0 enters powerdown, 1 does not.
// R19: Leader strap low gives advertised and forced leader bits zero, high gives one.
// R20: Latched strap values stay fixed until the next reset.
module strap_config_tx_level
  import strap_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Strap pins, asynchronous levels
  input  wire logic        high_level_disable_strap,
  input  wire logic        mac_if_select_upper_strap,
  input  wire logic        mac_if_select_lower_strap,
  input  wire logic        media_bridge_strap,
  input  wire logic        powerdown_skip_strap,
  input  wire logic        leader_preference_strap,
  // Register access port
  input  wire mgmt_req_t   mgmt_req,
  output logic [15:0]      mgmt_rdata_q,
  output logic             mgmt_rvalid_q,
  // Negotiation engine status
  input  wire logic        an_enable,
  input  wire logic        an_done,
  input  wire logic        lp_high_ability,
  input  wire logic        lp_high_request,
  // Configuration outputs
  output logic             tx_level_high_q,
  output mac_mode_t        mac_mode_q,
  output logic             media_bridge_q,
  output logic             soft_powerdown_q,
  output logic             an_start_q,
  output logic             link_bringup_q,
  output logic             adv_leader_q,
  output logic             forced_leader_q,
  output logic             cfg_done_q
);

  // ==========================================================
  // Strap synchronisation and capture
  strap_bits_t pin_now;
  strap_bits_t pin_sync;
  strap_bits_t straps_q;
  logic [1:0]  settle_q;
  cfg_state_t  state_q;
  logic        capture;

  assign pin_now = '{high_level_disable: high_level_disable_strap,
                     mac_upper:          mac_if_select_upper_strap,
                     mac_lower:          mac_if_select_lower_strap,
                     media_bridge:       media_bridge_strap,
                     powerdown_skip:     powerdown_skip_strap,
                     leader_pref:        leader_preference_strap};

  strap_sync #(
    .WIDTH   ($bits(strap_bits_t))
  ) u_sync (
    .core_clk(core_clk),
    .rst_b   (rst_b),
    .pin_in  (pin_now),
    .sync_q  (pin_sync)
  );

  // Wait until the synchroniser holds post-reset levels before sampling
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= 2'd0;
    end else if (settle_q != `STRAP_SETTLE) begin
      settle_q <= settle_q + 2'd1;
    end
  end

  assign capture = (state_q == ST_CAPTURE) && (settle_q == `STRAP_SETTLE);

  // R17 latch straps once
  // R20 held until reset, pins later carry functional data
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      straps_q   <= '0;
      cfg_done_q <= 1'b0;
    end else if (capture) begin
      straps_q   <= pin_sync;
      cfg_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // Register access decode
  logic wr_ok;
  logic hit_adv_mid, hit_adv_high, hit_leader, hit_lvl_ctrl;
  logic hit_lvl_able, hit_soft_pd, hit_sys, hit_cfg;

  // Writes before capture are dropped so straps cannot be overrun
  assign wr_ok        = mgmt_req.wr && cfg_done_q;
  assign hit_adv_mid  = (mgmt_req.dev == `DEV_AN)   && (mgmt_req.addr == `REG_ADV_MID);
  assign hit_adv_high = (mgmt_req.dev == `DEV_AN)   && (mgmt_req.addr == `REG_ADV_HIGH);
  assign hit_leader   = (mgmt_req.dev == `DEV_PMA)  && (mgmt_req.addr == `REG_LEADER_CFG);
  assign hit_lvl_ctrl = (mgmt_req.dev == `DEV_PMA)  && (mgmt_req.addr == `REG_TX_LVL_CTRL);
  assign hit_lvl_able = (mgmt_req.dev == `DEV_PMA)  && (mgmt_req.addr == `REG_TX_LVL_ABLE);
  assign hit_soft_pd  = (mgmt_req.dev == `DEV_VEND) && (mgmt_req.addr == `REG_SOFT_PD);
  assign hit_sys      = (mgmt_req.dev == `DEV_VEND) && (mgmt_req.addr == `REG_SYS_STATUS);
  assign hit_cfg      = (mgmt_req.dev == `DEV_VEND) && (mgmt_req.addr == `REG_CFG_STATUS);

  // ==========================================================
  // Transmit-level configuration bits
  logic cap_q;
  logic adv_abl_q;
  logic adv_req_q;
  logic forced_hi_q;

  // R1 capability set by low strap
  // R2 capability cleared by high strap, read-only afterwards
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_q <= 1'b0;
    end else if (capture) begin
      cap_q <= !pin_sync.high_level_disable;
    end
  end

  // R3 defaults follow capability
  // R4 a one is masked off when capability is zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_abl_q   <= 1'b0;
      adv_req_q   <= 1'b0;
      forced_hi_q <= 1'b0;
    end else if (capture) begin
      adv_abl_q   <= !pin_sync.high_level_disable;
      adv_req_q   <= !pin_sync.high_level_disable;
      forced_hi_q <= !pin_sync.high_level_disable;
    end else if (wr_ok && hit_adv_high) begin
      adv_abl_q   <= mgmt_req.wdata[`BIT_ADV_HI_ABL] & cap_q;
      adv_req_q   <= mgmt_req.wdata[`BIT_ADV_HI_REQ] & cap_q;
    end else if (wr_ok && hit_lvl_ctrl) begin
      forced_hi_q <= mgmt_req.wdata[`BIT_TX_LVL_HI] & cap_q;
    end
  end

  // ==========================================================
  // Leader preference bits
  // R15 strap picks prefer slave or prefer master
  // R19 both leader bits default to strap level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      adv_leader_q    <= 1'b0;
      forced_leader_q <= 1'b0;
    end else if (capture) begin
      adv_leader_q    <= pin_sync.leader_pref;
      forced_leader_q <= pin_sync.leader_pref;
    end else if (wr_ok && hit_adv_mid) begin
      adv_leader_q    <= mgmt_req.wdata[`BIT_ADV_LEADER];
    end else if (wr_ok && hit_leader) begin
      forced_leader_q <= mgmt_req.wdata[`BIT_FORCED_LEADER];
    end
  end

  // ==========================================================
  // MAC interface mode and media converter
  // R8 two-bit select decode
  // R9 pulled-down straps read 00 which is RMII
  // R10 bridge strap level selects converter
  // R11 converter only with RMII
  // R12 bridge enable steers the RMII port to the line side
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mac_mode_q     <= MAC_RMII;
      media_bridge_q <= 1'b0;
    end else if (capture) begin
      mac_mode_q     <= mac_mode_t'({pin_sync.mac_upper, pin_sync.mac_lower});
      media_bridge_q <= pin_sync.media_bridge && !pin_sync.mac_upper && !pin_sync.mac_lower;
    end
  end

  // ==========================================================
  // Soft powerdown and bring-up sequence
  cfg_state_t state_d;

  // R18 skip strap gives the powerdown default
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_powerdown_q <= 1'b0;
    end else if (capture) begin
      soft_powerdown_q <= !pin_sync.powerdown_skip;
    end else if (wr_ok && hit_soft_pd) begin
      soft_powerdown_q <= mgmt_req.wdata[`BIT_SOFT_PD];
    end
  end

  // R13 skip goes straight to negotiation
  // R14 powerdown held until the host clears the bit
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CAPTURE: begin
        if (capture) begin
          state_d = pin_sync.powerdown_skip ? ST_RUN : ST_POWERDOWN;
        end
      end
      ST_POWERDOWN: begin
        if (!soft_powerdown_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (soft_powerdown_q) begin
          state_d = ST_POWERDOWN;
        end
      end
      default: begin
        state_d = ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_CAPTURE;
    end else begin
      state_q <= state_d;
    end
  end

  // R13 one start pulse on each entry to run, link once negotiation completes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      an_start_q     <= 1'b0;
      link_bringup_q <= 1'b0;
    end else begin
      an_start_q     <= (state_d == ST_RUN) && (state_q != ST_RUN);
      link_bringup_q <= (state_q == ST_RUN) && (!an_enable || an_done);
    end
  end

  // ==========================================================
  // Transmit level resolution
  // R5 forced bit only without negotiation
  // R6 both able and one request
  // R7 no local ability keeps 1.0 V; until resolved also 1.0 V
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_level_high_q <= 1'b0;
    end else if (!an_enable) begin
      tx_level_high_q <= forced_hi_q & cap_q;
    end else if (an_done) begin
      tx_level_high_q <= adv_abl_q & lp_high_ability & (adv_req_q | lp_high_request);
    end else begin
      tx_level_high_q <= 1'b0;
    end
  end

  // ==========================================================
  // Read data, one cycle after the request; unmapped reads give zero
  logic [15:0] rdata_d;

  always_comb begin
    rdata_d = `WORD_ZERO;
    if (hit_adv_mid) begin
      rdata_d[`BIT_ADV_LEADER] = adv_leader_q;
    end else if (hit_adv_high) begin
      rdata_d[`BIT_ADV_HI_ABL] = adv_abl_q;
      rdata_d[`BIT_ADV_HI_REQ] = adv_req_q;
    end else if (hit_leader) begin
      rdata_d[`BIT_FORCED_LEADER] = forced_leader_q;
    end else if (hit_lvl_ctrl) begin
      rdata_d[`BIT_TX_LVL_HI] = forced_hi_q;
    end else if (hit_lvl_able) begin
      rdata_d[`BIT_TX_LVL_ABLE] = cap_q;
    end else if (hit_soft_pd) begin
      rdata_d[`BIT_SOFT_PD] = soft_powerdown_q;
    end else if (hit_sys) begin
      rdata_d[`BIT_SYS_READY]   = cfg_done_q;
      rdata_d[`BIT_SOFT_PD_RDY] = (state_q == ST_POWERDOWN);
    end else if (hit_cfg) begin
      rdata_d[`BIT_STAT_MAC_LO]  = mac_mode_q[0];
      rdata_d[`BIT_STAT_MAC_HI]  = mac_mode_q[1];
      rdata_d[`BIT_STAT_BRIDGE]  = media_bridge_q;
      rdata_d[`BIT_STAT_LVL_HI]  = tx_level_high_q;
      rdata_d[`BIT_STAT_LATCHED] = cfg_done_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_rdata_q  <= `WORD_ZERO;
      mgmt_rvalid_q <= 1'b0;
    end else begin
      mgmt_rdata_q  <= mgmt_req.rd ? rdata_d : `WORD_ZERO;
      mgmt_rvalid_q <= mgmt_req.rd;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_cap_set_low: assert property ($rose(cfg_done_q) && !straps_q.high_level_disable |-> cap_q) // R1
    else $error("capability not set for low strap");
  a_cap_clear_high: assert property ($rose(cfg_done_q) && straps_q.high_level_disable |-> !cap_q) // R2
    else $error("capability not cleared for high strap");
  a_defaults_match: assert property ($rose(cfg_done_q) |->
      adv_abl_q == cap_q && adv_req_q == cap_q && forced_hi_q == cap_q) // R3
    else $error("level defaults differ from capability");
  a_write_blocked: assert property (cfg_done_q && !cap_q |-> !adv_abl_q && !adv_req_q && !forced_hi_q) // R4
    else $error("high level bit set without capability");
  a_forced_level: assert property (cfg_done_q && !an_enable |=> tx_level_high_q == $past(forced_hi_q & cap_q)) // R5
    else $error("forced level not applied");
  a_an_resolve: assert property (an_enable && an_done |=>
      tx_level_high_q == $past(adv_abl_q & lp_high_ability & (adv_req_q | lp_high_request))) // R6
    else $error("negotiated level wrong");
  a_no_ability_low: assert property (an_enable && !adv_abl_q |=> !tx_level_high_q) // R7
    else $error("high level without local ability");
  a_mac_decode: assert property (cfg_done_q |-> mac_mode_q == mac_mode_t'({straps_q.mac_upper, straps_q.mac_lower})) // R8
    else $error("mac mode decode wrong");
  a_bridge_rmii: assert property (media_bridge_q |-> mac_mode_q == MAC_RMII && straps_q.media_bridge) // R11
    else $error("bridge active outside rmii");
  a_skip_start: assert property ($rose(cfg_done_q) && straps_q.powerdown_skip |-> an_start_q ##1 !an_start_q) // R13
    else $error("no start pulse after skip");
  a_pd_hold: assert property (state_q == ST_POWERDOWN && soft_powerdown_q |=> !an_start_q && !link_bringup_q) // R14
    else $error("started while in powerdown");
  a_pd_default: assert property ($rose(cfg_done_q) |-> soft_powerdown_q == !straps_q.powerdown_skip) // R18
    else $error("powerdown default wrong");
  a_leader_default: assert property ($rose(cfg_done_q) |->
      adv_leader_q == straps_q.leader_pref && forced_leader_q == straps_q.leader_pref) // R19
    else $error("leader defaults wrong");
  a_straps_stable: assert property (cfg_done_q |=> $stable(straps_q) && cfg_done_q) // R20
    else $error("latched straps changed");

  c_skip_start: cover property ($rose(cfg_done_q) && an_start_q);
  c_pd_exit: cover property (state_q == ST_POWERDOWN ##1 state_q == ST_RUN);
  c_high_level: cover property (an_enable && an_done ##1 tx_level_high_q);
  c_write_masked: cover property (wr_ok && hit_adv_high && !cap_q && mgmt_req.wdata[`BIT_ADV_HI_ABL]);

endmodule : strap_config_tx_level

/* File: sim/strap_board.sv */
// Board strap resistors with shared functional pin activity
`timescale 1ns/1ps
module strap_board
  import strap_cfg_pkg::*;
(
  // Clock for the functional pin pattern
  input  wire logic        core_clk,
  // Fitted pull-up pattern and functional drive enable
  input  wire strap_bits_t fit,
  input  wire logic        func_on,
  // Strap pin levels
  output logic             hld_pin,
  output logic             up_pin,
  output logic             lo_pin,
  output logic             mb_pin,
  output logic             skip_pin,
  output logic             lead_pin
);
  logic        tog_q = 1'b0;
  strap_bits_t lvl;

  // Toggling pattern so a late capture never sees a steady strap level
  always_ff @(posedge core_clk) begin
    tog_q <= ~tog_q;
  end

  assign lvl = func_on ? (fit ^ {6{tog_q}}) : fit;
  assign {hld_pin, up_pin, lo_pin, mb_pin, skip_pin, lead_pin} = lvl;
endmodule : strap_board

/* File: sim/testbench.sv */
// Self-checking bench for the strap configuration loader
`timescale 1ns/1ps
`include "strap_cfg_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench
  import strap_cfg_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  strap_bits_t fit = '0;
  logic        func_on = 1'b0;
  mgmt_req_t   req = '0;
  logic        an_en = 1'b0, an_dn = 1'b0, lpa = 1'b0, lpr = 1'b0;
  logic        hld, up, lo, mb, skip, lead;
  logic [15:0] rdata, v;
  logic        rvalid, lvl_hi, bridge, spd, an_start, link, adv_ld, frc_ld, done;
  mac_mode_t   mode;
  int          bad_count = 0, compares = 0, starts = 0, base;

  // ==========================================================
  // Clock, strap board and design
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  strap_board board (.core_clk(core_clk), .fit(fit), .func_on(func_on), .hld_pin(hld), .up_pin(up),
    .lo_pin(lo), .mb_pin(mb), .skip_pin(skip), .lead_pin(lead));

  strap_config_tx_level DUT (.core_clk(core_clk), .rst_b(rst_b), .high_level_disable_strap(hld),
    .mac_if_select_upper_strap(up), .mac_if_select_lower_strap(lo), .media_bridge_strap(mb),
    .powerdown_skip_strap(skip), .leader_preference_strap(lead), .mgmt_req(req),
    .mgmt_rdata_q(rdata), .mgmt_rvalid_q(rvalid), .an_enable(an_en), .an_done(an_dn),
    .lp_high_ability(lpa), .lp_high_request(lpr), .tx_level_high_q(lvl_hi), .mac_mode_q(mode),
    .media_bridge_q(bridge), .soft_powerdown_q(spd), .an_start_q(an_start), .link_bringup_q(link),
    .adv_leader_q(adv_ld), .forced_leader_q(frc_ld), .cfg_done_q(done));

  // Start pulses counted so a missing or extra one shows up
  always @(posedge core_clk) begin
    if (an_start === 1'b1) starts <= starts + 1;
  end

  // ==========================================================
  // Access tasks
  task automatic do_reset(input strap_bits_t s);
    int n;
    fit <= s;
    func_on <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    base = starts;
    rst_b <= 1'b1;
    for (n = 0; n < 10 && done !== 1'b1; n++) @(posedge core_clk);
    #1;
  endtask : do_reset

  task automatic reg_rd(input logic [4:0] dev, input logic [15:0] addr, output logic [15:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, dev: dev, addr: addr, wdata: 16'h0000};
    @(posedge core_clk);
    req <= '0;
    #1 d = (rvalid === 1'b1) ? rdata : 16'hdead;
  endtask : reg_rd

  task automatic reg_wr(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, dev: dev, addr: addr, wdata: d};
    @(posedge core_clk);
    req <= '0;
  endtask : reg_wr

  // Negotiation inputs applied, result checked two edges later
  task automatic level(input logic en, input logic dn, input logic a, input logic r, input logic e);
    @(posedge core_clk);
    {an_en, an_dn, lpa, lpr} <= {en, dn, a, r};
    repeat (2) @(posedge core_clk);
    #1 `CHK(lvl_hi, e)
  endtask : level

  task automatic rd_chk(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] e);
    reg_rd(dev, addr, v);
    `CHK(v, e)
  endtask : rd_chk

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 8);
    bad_count++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    // Defaults with only the internal pull-downs
    do_reset(6'b000000);
    `CHK(done, 1'b1)
    rd_chk(`DEV_VEND, `REG_SYS_STATUS, 16'h0003);
    rd_chk(`DEV_PMA, `REG_TX_LVL_ABLE, 16'h1000);
    rd_chk(`DEV_AN, `REG_ADV_HIGH, 16'h3000);
    rd_chk(`DEV_PMA, `REG_TX_LVL_CTRL, 16'h1000);
    rd_chk(`DEV_VEND, 16'h1234, 16'h0000);
    `CHK(mode, MAC_RMII)
    `CHK(bridge, 1'b0)
    `CHK(spd, 1'b1)
    `CHK({adv_ld, frc_ld}, 2'b00)
    // Shared pins toggling after capture must not disturb latched values
    func_on <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 `CHK({mode, bridge, spd, adv_ld}, 5'b00010)
    `CHK(starts - base, 0)
    `CHK(link, 1'b0)
    func_on <= 1'b0;
    level(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    reg_wr(`DEV_PMA, `REG_TX_LVL_CTRL, 16'h0000);
    level(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    level(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    // Every local and partner advertisement combination
    for (int i = 0; i < 16; i++) begin
      // host writes ability and request bits to steer the level
      reg_wr(`DEV_AN, `REG_ADV_HIGH, {2'b00, i[3:2], 12'h000});
      level(1'b1, 1'b1, i[1], i[0], i[3] & i[1] & (i[2] | i[0]));
    end
    // Host clears soft powerdown, negotiation starts once
    // host releases powerdown
    // Negotiation off so the link follows run state directly
    @(posedge core_clk);
    an_en <= 1'b0;
    reg_wr(`DEV_VEND, `REG_SOFT_PD, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1 `CHK(starts - base, 1)
    `CHK({spd, link}, 2'b01)
    rd_chk(`DEV_VEND, `REG_SYS_STATUS, 16'h0001);
    $display("Test defaults finished");

    // All straps pulled up
    do_reset(6'b111111);
    `CHK(starts - base, 1)
    `CHK(spd, 1'b0)
    rd_chk(`DEV_PMA, `REG_TX_LVL_ABLE, 16'h0000);
    rd_chk(`DEV_AN, `REG_ADV_HIGH, 16'h0000);
    rd_chk(`DEV_PMA, `REG_TX_LVL_CTRL, 16'h0000);
    reg_wr(`DEV_AN, `REG_ADV_HIGH, 16'h3000);
    reg_wr(`DEV_PMA, `REG_TX_LVL_CTRL, 16'h1000);
    rd_chk(`DEV_AN, `REG_ADV_HIGH, 16'h0000);
    rd_chk(`DEV_PMA, `REG_TX_LVL_CTRL, 16'h0000);
    rd_chk(`DEV_AN, `REG_ADV_MID, 16'h0010);
    rd_chk(`DEV_PMA, `REG_LEADER_CFG, 16'h4000);
    `CHK({adv_ld, frc_ld}, 2'b11)
    `CHK(mode, MAC_MII)
    `CHK(bridge, 1'b0)
    level(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    `CHK(link, 1'b1)
    rd_chk(`DEV_VEND, `REG_CFG_STATUS, 16'h0013);
    $display("Test pulled up finished");

    // Every select code with the converter strap fitted
    for (int m = 0; m < 4; m++) begin
      do_reset({1'b0, m[1:0], 1'b1, 2'b00});
      `CHK(mode, mac_mode_t'(m[1:0]))
      `CHK(bridge, m == 0)
      // Partner still able and requesting, so the level resolves high
      rd_chk(`DEV_VEND, `REG_CFG_STATUS, {11'h000, 1'b1, 1'b1, m == 0, m[1:0]});
    end
    $display("Test interface codes finished");
    summarize();
  end
endmodule : testbench
